/* File: rtl/pocs_chan.v */
`timescale 1ns/1ns
`default_nettype none
module pocs_chan #(
  parameter DIV_W = 7,
  parameter DLY_W = 3
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             ph,
  input  wire             qtick,
  input  wire [DIV_W-1:0] div,
  input  wire [DLY_W-1:0] dly,
  input  wire             unused,
  input  wire             req,
  output reg              clk_out,
  output reg              running
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_WAIT = 2'd1;
  localparam [1:0] ST_RUN  = 2'd2;

  reg  [1:0]       state;
  reg              req_s1;
  reg              req_s2;
  reg              ph_d;
  reg  [DIV_W-1:0] cnt;
  reg  [DLY_W-1:0] dcnt;
  reg              gate;
  wire [DIV_W-1:0] div_eff = (div == {DIV_W{1'b0}}) ? {{(DIV_W-1){1'b0}}, 1'b1} : div;
  wire [DIV_W:0]   half_w  = {1'b0, div_eff} + {{DIV_W{1'b0}}, 1'b1};
  wire [DIV_W-1:0] half    = half_w[DIV_W:1];
  wire             rise    = ph & ~ph_d;
  wire             run_st  = (state == ST_RUN);
  wire             want    = req_s2 & ~unused;
  wire             dout    = ~run_st ? 1'b0 :
                             (div_eff == {{(DIV_W-1){1'b0}}, 1'b1}) ? ph : (cnt < half);

  always @(posedge aclk) begin
    if (!aresetn) begin
      state   <= ST_IDLE;
      req_s1  <= 1'b0;
      req_s2  <= 1'b0;
      ph_d    <= 1'b0;
      cnt     <= {DIV_W{1'b0}};
      dcnt    <= {DLY_W{1'b0}};
      gate    <= 1'b0;
      clk_out <= 1'b0;
      running <= 1'b0;
    end else begin
      req_s1  <= req;
      req_s2  <= req_s1;
      ph_d    <= ph;
      if (!dout) begin
        gate <= want & run_st;
      end
      clk_out <= unused ? 1'b0 : (gate & dout);
      running <= gate;
      case (state)
        ST_IDLE: begin
          cnt  <= {DIV_W{1'b0}};
          dcnt <= {DLY_W{1'b0}};
          if (want) begin
            state <= (dly == {DLY_W{1'b0}}) ? ST_RUN : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!want) begin
            state <= ST_IDLE;
          end else if (qtick) begin
            if (dcnt == dly - {{(DLY_W-1){1'b0}}, 1'b1}) begin
              state <= ST_RUN;
            end else begin
              dcnt <= dcnt + {{(DLY_W-1){1'b0}}, 1'b1};
            end
          end
        end
        ST_RUN: begin
          if (rise) begin
            if (cnt >= div_eff - {{(DIV_W-1){1'b0}}, 1'b1}) begin
              cnt <= {DIV_W{1'b0}};
            end else begin
              cnt <= cnt + {{(DIV_W-1){1'b0}}, 1'b1};
            end
          end
          if (!want && !gate && !dout) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: rtl/pocs_map.vh */
`ifndef POCS_MAP_VH
`define POCS_MAP_VH
`define POCS_NUM_PH        8
`define POCS_NUM_CH        4
`define POCS_OFS_CTRL      8'h00
`define POCS_OFS_FBDIV     8'h04
`define POCS_OFS_STATUS    8'h08
`define POCS_OFS_CH0       8'h10
`define POCS_OFS_CH3       8'h1c
`define POCS_CTRL_EN_LSB   0
`define POCS_CTRL_SRC_LSB  4
`define POCS_CTRL_OFF_LSB  8
`define POCS_FB_FRAC_W     24
`define POCS_FB_INT_W      8
`define POCS_FB_RST        32'h40000000
`define POCS_CH_SEL_LSB    0
`define POCS_CH_DIV_LSB    4
`define POCS_CH_DLY_LSB    12
`define POCS_DIV_W         7
`define POCS_DIV_RST       7'h01
`define POCS_DLY_W         3
`define POCS_CH_RST        32'h00000010
`define POCS_RESP_OKAY     2'b00
`define POCS_RESP_SLVERR   2'b10
`endif

/* File: rtl/pocs_top.v */
`timescale 1ns/1ns
`default_nettype none
`include "pocs_map.vh"
module pocs_top #(
  parameter NUM_CH = 4,
  parameter DIV_W  = 7,
  parameter DLY_W  = 3
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire [NUM_CH-1:0] fab_en,
  output reg  [7:0]        phase_out,
  output wire [NUM_CH-1:0] clk_out
);
  reg  [31:0]       ctrl;
  reg  [31:0]       fbdiv;
  reg  [31:0]       chcfg [0:NUM_CH-1];
  reg  [31:0]       acc;
  reg  [2:0]        idx;
  reg  [1:0]        qcnt;
  reg               qtick;
  reg               aw_held;
  reg               w_held;
  reg  [7:0]        aw_addr;
  reg  [31:0]       w_data;
  reg  [3:0]        w_strb;
  wire [32:0]       acc_sum = {1'b0, acc} + {1'b0, fbdiv};
  wire              osc_tick = acc_sum[32];
  wire [NUM_CH-1:0] running;
  wire [NUM_CH-1:0] req;
  wire [7:0]        next_phase;
  wire              do_write = aw_held & w_held & ~s_axi_bvalid;
  wire              aw_ok = (aw_addr[1:0] == 2'b00) &&
                            ((aw_addr == `POCS_OFS_CTRL) || (aw_addr == `POCS_OFS_FBDIV) ||
                             ((aw_addr >= `POCS_OFS_CH0) && (aw_addr <= `POCS_OFS_CH3)));
  wire [1:0]        aw_ch = aw_addr[3:2];
  wire [1:0]        ar_ch = s_axi_araddr[3:2];
  integer           k;

  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;

  // oscillator phase ring driven by fractional accumulator
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc   <= 32'h00000000;
      idx   <= 3'h0;
      qcnt  <= 2'h0;
      qtick <= 1'b0;
    end else begin
      acc   <= acc_sum[31:0];
      qtick <= 1'b0;
      if (osc_tick) begin
        idx  <= idx + 3'h1;
        qcnt <= qcnt + 2'h1;
        qtick <= (qcnt == 2'h3);
      end
    end
  end

  genvar p;
  generate
    for (p = 0; p < 8; p = p + 1) begin : g_ph
      localparam [31:0] PH_OFS = p;
      wire [2:0] rel = idx - PH_OFS[2:0];
      assign next_phase[p] = ~rel[2];
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      phase_out <= 8'h00;
    end else begin
      phase_out <= next_phase;
    end
  end

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c = c + 1) begin : g_ch
      assign req[c] = ctrl[`POCS_CTRL_SRC_LSB + c] ? fab_en[c]
                                                   : ctrl[`POCS_CTRL_EN_LSB + c];
      pocs_chan #(
        .DIV_W (DIV_W),
        .DLY_W (DLY_W)
      ) u_chan (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ph      (phase_out[chcfg[c][`POCS_CH_SEL_LSB +: 3]]),
        .qtick   (qtick),
        .div     (chcfg[c][`POCS_CH_DIV_LSB +: DIV_W]),
        .dly     (chcfg[c][`POCS_CH_DLY_LSB +: DLY_W]),
        .unused  (ctrl[`POCS_CTRL_OFF_LSB + c]),
        .req     (req[c]),
        .clk_out (clk_out[c]),
        .running (running[c])
      );
    end
  endgenerate

  // write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `POCS_RESP_OKAY;
      ctrl         <= 32'h00000000;
      fbdiv        <= `POCS_FB_RST;
      for (k = 0; k < NUM_CH; k = k + 1) begin
        chcfg[k] <= `POCS_CH_RST;
      end
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_ok ? `POCS_RESP_OKAY : `POCS_RESP_SLVERR;
        for (k = 0; k < 4; k = k + 1) begin
          if (w_strb[k]) begin
            if (aw_addr == `POCS_OFS_CTRL) begin
              ctrl[k*8 +: 8] <= w_data[k*8 +: 8];
            end
            if (aw_addr == `POCS_OFS_FBDIV) begin
              fbdiv[k*8 +: 8] <= w_data[k*8 +: 8];
            end
            if (aw_ok && (aw_addr >= `POCS_OFS_CH0)) begin
              chcfg[aw_ch][k*8 +: 8] <= w_data[k*8 +: 8];
            end
          end
        end
      end
    end
  end

  // read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `POCS_RESP_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `POCS_RESP_OKAY;
        s_axi_rdata  <= 32'h00000000;
        if (s_axi_araddr == `POCS_OFS_CTRL) begin
          s_axi_rdata <= ctrl & 32'h00000fff;
        end else if (s_axi_araddr == `POCS_OFS_FBDIV) begin
          s_axi_rdata <= fbdiv;
        end else if (s_axi_araddr == `POCS_OFS_STATUS) begin
          s_axi_rdata <= {{(32-NUM_CH){1'b0}}, running};
        end else if ((s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr >= `POCS_OFS_CH0) &&
                     (s_axi_araddr <= `POCS_OFS_CH3)) begin
          s_axi_rdata <= chcfg[ar_ch] & 32'h00007ff7;
        end else begin
          s_axi_rresp <= `POCS_RESP_SLVERR;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/pocs_chk_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module pocs_chk #(parameter NUM_CH = 4) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [7:0]        phase_out,
  input wire logic [NUM_CH-1:0] clk_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [5:0] warm;
  always_ff @(posedge aclk) begin
    if (!aresetn) warm <= 6'h00;
    else if (warm != 6'h3f) warm <= warm + 6'h01;
  end
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_wr_answer: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  a_phase_lag: assert property (warm == 6'h3f |-> phase_out[1] == $past(phase_out[0], 4))
    else $error("phase spacing wrong");
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    a_high_whole: assert property ($rose(clk_out[i]) |=> clk_out[i] [*8])
      else $error("short high pulse");
    a_low_whole: assert property ($fell(clk_out[i]) |=> !clk_out[i] [*8])
      else $error("short low pulse");
  end
endmodule
bind pocs_top pocs_chk #(.NUM_CH(NUM_CH)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .phase_out(phase_out), .clk_out(clk_out));
`default_nettype wire

/* File: verif/pocs_fab.sv */
`timescale 1ns/1ns
`default_nettype none
module pocs_fab (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] run,
  output logic      [3:0] fab_en
);
  always_ff @(posedge aclk) begin
    if (!aresetn) fab_en <= 4'h0;
    else fab_en <= run;
  end
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr, phase_out;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  run, fab_en, clk_out;
  int          num_errors, total_checks, cyc;
  pocs_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fab_en(fab_en), .phase_out(phase_out), .clk_out(clk_out));
  pocs_fab u_fab (.aclk(aclk), .aresetn(aresetn), .run(run), .fab_en(fab_en));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    r = 2'bxx;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready) begin
        r = bresp;
        break;
      end
      if (bvalid === 1'b1) bready <= 1'b1;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, e}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [1:0] r;
    r = 2'bxx;
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready) begin
        r = rresp;
        chk("rdata", e, rdata);
        break;
      end
      if (rvalid === 1'b1) rready <= 1'b1;
    end
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rise(input int ch, output int t);
    logic p;
    p = clk_out[ch];
    t = -1;
    repeat (9000) begin
      @(posedge aclk);
      if (clk_out[ch] === 1'b1 && p === 1'b0) begin
        t = cyc;
        break;
      end
      p = clk_out[ch];
    end
  endtask
  task automatic t_regs;
    rd(8'h04, 32'h40000000, 2'b00);
    rd(8'h10, 32'h00000010, 2'b00);
    rd(8'h0c, 32'h0, 2'b10);
    wr(8'h0c, 32'hffffffff, 2'b10);
    wr(8'h04, 32'h40000001, 2'b00);
    rd(8'h04, 32'h40000001, 2'b00);
  endtask
  task automatic t_phase;
    int t0, t1, t2;
    wr(8'h14, 32'h00000012, 2'b00);
    wr(8'h00, 32'h00000003, 2'b00);
    rise(0, t0);
    rise(1, t1);
    rise(0, t2);
    chk("lag", 8, (t1 - t0) % 32);
    chk("period", 32, t2 - t0);
    chk("phase ones", 4, $countones(phase_out));
    chk("phase half", {31'h0, ~phase_out[0]}, {31'h0, phase_out[4]});
    rd(8'h08, 32'h3, 2'b00);
    wr(8'h00, 32'h0, 2'b00);
    repeat (80) @(posedge aclk);
    rd(8'h08, 32'h0, 2'b00);
    chk("stopped", 4'h0, clk_out);
  endtask
  task automatic t_div;
    int t0, t1, t2, t3;
    wr(8'h14, 32'h00000030, 2'b00);
    wr(8'h18, 32'h000007f0, 2'b00);
    wr(8'h00, 32'h00000024, 2'b00);
    run <= 4'h2;
    rise(1, t0);
    rise(1, t1);
    chk("div3", 96, t1 - t0);
    rise(2, t2);
    rise(2, t3);
    chk("div127", 4064, t3 - t2);
    run <= 4'h0;
    wr(8'h00, 32'h00000020, 2'b00);
    repeat (2200) @(posedge aclk);
    chk("fab stop", 4'h0, clk_out);
  endtask
  task automatic t_gate;
    int s, t;
    logic hi;
    hi = 1'b0;
    wr(8'h00, 32'h00000808, 2'b00);
    repeat (300) begin
      @(posedge aclk);
      hi = hi | clk_out[3];
    end
    chk("unused", 1'b0, hi);
    s = cyc;
    wr(8'h00, 32'h00000008, 2'b00);
    rise(3, t);
    chk("dly0", 1, t > 0 && t - s < 112);
    wr(8'h00, 32'h0, 2'b00);
    repeat (100) @(posedge aclk);
    wr(8'h1c, 32'h00007010, 2'b00);
    s = cyc;
    wr(8'h00, 32'h00000008, 2'b00);
    rise(3, t);
    chk("dly7", 1, t - s >= 100 && t - s < 170);
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, run} = 52'h0;
    {num_errors, total_checks, cyc} = 0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_phase;
    t_div;
    t_gate;
    report_and_stop;
  end
  initial begin
    #4000000;
    num_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
